/* File: hw/psq_pkg.sv */
// Shared constants and types for the program sequencer core
package psq_pkg;

  // ----------------------------------------------------------------
  // Widths and vectors
  // ----------------------------------------------------------------
  localparam int PC_W = 10;
  localparam int INSTR_W = 13;
  localparam int STACK_DEPTH = 2;
  localparam logic [9:0] RESET_VECTOR = 10'h000;
  localparam logic [9:0] TIMEBASE_VECTOR = 10'h008;
  localparam logic [1:0] STACK_FULL_LVL = 2'h2;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_PC_LOW_BYTE = 12'h000;
  localparam logic [11:0] OFF_CORE_STATUS = 12'h004;
  localparam int CORE_ACC_LSB = 0;
  localparam int CORE_FLAG_LSB = 8;
  localparam int CORE_LVL_LSB = 12;
  localparam int CORE_PEND_BIT = 14;
  localparam int CORE_EMI_BIT = 15;
  localparam int CORE_DUMMY_BIT = 16;

  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int INS_BRANCH_BIT = 12;
  localparam int INS_CALL_BIT = 10;
  localparam int INS_OP_MSB = 11;
  localparam int INS_OP_LSB = 7;
  localparam logic [12:0] INSTR_NOP = 13'h0000;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } psq_phase_t;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_MOVI = 5'h01, OP_ADDI = 5'h02, OP_ADCI = 5'h03,
    OP_SUBI = 5'h04, OP_SBCI = 5'h05, OP_ANDI = 5'h06, OP_ORI = 5'h07,
    OP_XORI = 5'h08, OP_CPLA = 5'h09, OP_RRA = 5'h0a, OP_RLA = 5'h0b,
    OP_RRCA = 5'h0c, OP_RLCA = 5'h0d, OP_INCA = 5'h0e, OP_DECA = 5'h0f,
    OP_SWAPA = 5'h10, OP_DAA = 5'h11, OP_SZA = 5'h12, OP_SNZA = 5'h13,
    OP_RET = 5'h14, OP_INTERRUPT_RETURN_OP = 5'h15, OP_MOVPCL = 5'h16, OP_RETA = 5'h17,
    OP_EI = 5'h18
  } psq_op_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } psq_flags_t;

  localparam psq_flags_t FLAGS_RESET = 4'h0;

endpackage : psq_pkg

/* File: hw/psq_sequencer.sv */
// Program sequencer: phases, program counter, stack, ALU and APB slave
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Functional notes
// - System clock splits into four phases; four phases form one cycle.
// - Program counter advances and a fetch starts at first phase.
// - Fetch overlaps execute; control transfers cost one extra cycle.
// - Program counter increments by one unless control is transferred.
// - Program counter is ten bits; only low byte is software visible.
// - Low byte write jumps within current page with one dummy cycle.
// - Taken skip discards fetched instruction and runs a dummy cycle.
// - Jumps, calls, interrupts and reset load target address directly.
// - Two-entry return stack, not readable or writable by software.
// - Call or interrupt pushes counter; returns restore it from stack.
// - Reset sets stack pointer to top of stack.
// - Interrupt pends but is not acknowledged while stack is full.
// - Call on full stack still runs; oldest saved address is lost.
// - Eight-bit ALU for arithmetic, logic, rotate, step and branches.
// - ALU operations update carry, borrow and other status flags.
// - Immediate data carries only a low nibble; high nibble is zero.
// - Reset starts at address zero; time-base interrupt has fixed entry.
module psq_sequencer
  import psq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [PC_W-1:0] progAddr,
  input wire logic [INSTR_W-1:0] progData,
  // Time-base interrupt and phase view
  input wire logic intReq,
  output logic intAck,
  output logic [3:0] instrPhase
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  psq_phase_t phase_ff;
  logic [PC_W-1:0] pc_ff, progAddr_ff;
  logic [INSTR_W-1:0] exec_ff;
  logic dummy_ff, intPend_ff, emi_ff, pclReq_ff, intAck_ff;
  logic [7:0] acc_ff, pclData_ff;
  psq_flags_t flags_ff;
  logic [1:0] lvl_ff;
  logic wrIdx_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire live = ~dummy_ff;
  wire cycleEnd = (phase_ff == PH_T4);
  wire isJmp = live & exec_ff[INS_BRANCH_BIT];
  wire isCall = isJmp & exec_ff[INS_CALL_BIT];
  wire [PC_W-1:0] jmpTarget = exec_ff[PC_W-1:0];
  wire isOp = live & ~exec_ff[INS_BRANCH_BIT];
  wire [4:0] opRaw = exec_ff[INS_OP_MSB:INS_OP_LSB];
  wire [7:0] imm8 = {4'h0, exec_ff[3:0]};
  wire accZero = (acc_ff == 8'h00);
  wire isRet = isOp & ((opRaw == OP_RET) | (opRaw == OP_INTERRUPT_RETURN_OP)
    | (opRaw == OP_RETA));
  wire isReti = isOp & (opRaw == OP_INTERRUPT_RETURN_OP);
  wire skipTaken = isOp & (((opRaw == OP_SZA) & accZero)
    | ((opRaw == OP_SNZA) & ~accZero));
  wire pclWrite = isOp & (opRaw == OP_MOVPCL);
  wire instrBranch = isJmp | isRet | skipTaken | pclWrite;
  wire stackFull = (lvl_ff == STACK_FULL_LVL);
  // Full stack holds off the acknowledge, the request stays pending
  wire intAckNow = ~instrBranch & intPend_ff & emi_ff & ~stackFull;
  wire applyPcl = pclReq_ff & ~instrBranch & ~intAckNow;
  wire takeBranch = instrBranch | intAckNow | applyPcl;
  wire doPush = isCall | intAckNow;
  wire doPop = isRet;
  wire [PC_W-1:0] stackTop;
  wire stackRdIdx = wrIdx_ff - 1'b1;

  // ----------------------------------------------------------------
  // Branch target
  // ----------------------------------------------------------------
  // Page bits come from the fetch address: same page as the instruction
  wire [1:0] curPage = progAddr_ff[PC_W-1:8];
  wire [PC_W-1:0] target =
    isJmp ? jmpTarget :
    isRet ? stackTop :
    skipTaken ? pc_ff :
    pclWrite ? {curPage, acc_ff} :
    intAckNow ? TIMEBASE_VECTOR :
    {curPage, pclData_ff};

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  logic [7:0] aluRes, addB;
  logic aluCin, accWr, flgWr;
  psq_flags_t aluFlags;
  logic [8:0] sum9, daaT, daaR;
  logic [4:0] sum5;

  always_comb begin
    addB = imm8;
    aluCin = 1'b0;
    unique case (opRaw)
      OP_SUBI: begin
        addB = ~imm8;
        aluCin = 1'b1;
      end
      OP_SBCI: begin
        addB = ~imm8;
        aluCin = flags_ff.c;
      end
      OP_ADCI: aluCin = flags_ff.c;
      OP_INCA: begin
        addB = 8'h00;
        aluCin = 1'b1;
      end
      OP_DECA: addB = 8'hff;
      default: begin
        addB = imm8;
        aluCin = 1'b0;
      end
    endcase
  end

  assign sum9 = {1'b0, acc_ff} + {1'b0, addB} + {8'h00, aluCin};
  assign sum5 = {1'b0, acc_ff[3:0]} + {1'b0, addB[3:0]} + {4'h0, aluCin};
  assign daaT = {1'b0, acc_ff}
    + (((acc_ff[3:0] > 4'h9) | flags_ff.ac) ? 9'h006 : 9'h000);
  assign daaR = daaT + (((daaT[7:4] > 4'h9) | flags_ff.c | daaT[8])
    ? 9'h060 : 9'h000);

  always_comb begin
    aluRes = acc_ff;
    aluFlags = flags_ff;
    accWr = 1'b1;
    flgWr = 1'b1;
    unique case (opRaw)
      OP_MOVI, OP_RETA: begin
        aluRes = imm8;
        flgWr = 1'b0;
      end
      OP_ADDI, OP_ADCI, OP_SUBI, OP_SBCI: begin
        aluRes = sum9[7:0];
        aluFlags.c = sum9[8];
        aluFlags.ac = sum5[4];
        aluFlags.ov = (acc_ff[7] == addB[7]) & (sum9[7] != acc_ff[7]);
      end
      OP_INCA, OP_DECA: aluRes = sum9[7:0];
      OP_ANDI: aluRes = acc_ff & imm8;
      OP_ORI: aluRes = acc_ff | imm8;
      OP_XORI: aluRes = acc_ff ^ imm8;
      OP_CPLA: aluRes = ~acc_ff;
      OP_RRA: begin
        aluRes = {acc_ff[0], acc_ff[7:1]};
        flgWr = 1'b0;
      end
      OP_RLA: begin
        aluRes = {acc_ff[6:0], acc_ff[7]};
        flgWr = 1'b0;
      end
      OP_RRCA: begin
        aluRes = {flags_ff.c, acc_ff[7:1]};
        aluFlags.c = acc_ff[0];
      end
      OP_RLCA: begin
        aluRes = {acc_ff[6:0], flags_ff.c};
        aluFlags.c = acc_ff[7];
      end
      OP_SWAPA: begin
        aluRes = {acc_ff[3:0], acc_ff[7:4]};
        flgWr = 1'b0;
      end
      OP_DAA: begin
        aluRes = daaR[7:0];
        aluFlags.c = flags_ff.c | daaT[8] | daaR[8];
      end
      default: begin
        accWr = 1'b0;
        flgWr = 1'b0;
      end
    endcase
    if (opRaw != OP_RRCA && opRaw != OP_RLCA) begin
      aluFlags.z = (aluRes == 8'h00);
    end
  end

  // Only a live instruction at its last phase commits results
  wire commitAcc = cycleEnd & isOp & accWr;
  wire commitFlg = cycleEnd & isOp & flgWr;

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Read data lags the pointer by one clock; the pointer only moves at
  // the last phase, so the top is settled long before the next use
  psq_stack_mem #(
    .WIDTH(PC_W),
    .DEPTH(STACK_DEPTH),
    .AW(1)
  ) u_stack (
    .clk(clk),
    .resetn(resetn),
    .wrEn(cycleEnd & doPush),
    .wrAddr(wrIdx_ff),
    .wrData(progAddr_ff),
    .rdAddr(stackRdIdx),
    .rdData_ff(stackTop)
  );

  // Pointer wraps, so a push on a full stack overwrites the oldest entry
  wire nxt_wrIdx = doPush ? ~wrIdx_ff : (doPop ? ~wrIdx_ff : wrIdx_ff);
  wire [1:0] nxt_lvl = doPush ? (stackFull ? lvl_ff : lvl_ff + 2'h1)
    : (doPop ? ((lvl_ff == 2'h0) ? lvl_ff : lvl_ff - 2'h1) : lvl_ff);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrIdx_ff <= 1'b0;
      lvl_ff <= 2'h0;
    end else if (cycleEnd) begin
      wrIdx_ff <= nxt_wrIdx;
      lvl_ff <= nxt_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Phases, program counter and pipeline
  // ----------------------------------------------------------------
  wire [PC_W-1:0] nxt_fetch = takeBranch ? target : pc_ff;
  wire nxt_intPend = intReq | (intPend_ff & ~(cycleEnd & intAckNow));
  wire nxt_emi = (cycleEnd & (isReti | (isOp & (opRaw == OP_EI))))
    | (emi_ff & ~(cycleEnd & intAckNow));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= PH_T1;
    end else begin
      unique case (phase_ff)
        PH_T1: phase_ff <= PH_T2;
        PH_T2: phase_ff <= PH_T3;
        PH_T3: phase_ff <= PH_T4;
        PH_T4: phase_ff <= PH_T1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      progAddr_ff <= RESET_VECTOR;
      pc_ff <= RESET_VECTOR + 10'h1;
      exec_ff <= INSTR_NOP;
      dummy_ff <= 1'b1;
    end else if (cycleEnd) begin
      progAddr_ff <= nxt_fetch;
      pc_ff <= nxt_fetch + 10'h1;
      exec_ff <= progData;
      dummy_ff <= takeBranch;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= 8'h00;
      flags_ff <= FLAGS_RESET;
    end else begin
      if (commitAcc) begin
        acc_ff <= aluRes;
      end
      if (commitFlg) begin
        flags_ff <= aluFlags;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intPend_ff <= 1'b0;
      emi_ff <= 1'b0;
      intAck_ff <= 1'b0;
    end else begin
      intPend_ff <= nxt_intPend;
      emi_ff <= nxt_emi;
      intAck_ff <= cycleEnd & intAckNow;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apbSetup = psel & ~penable;
  wire apbDone = psel & penable & pready_ff;
  wire selPcl = (paddr == OFF_PC_LOW_BYTE);
  wire selCore = (paddr == OFF_CORE_STATUS);
  wire wrPcl = apbDone & pwrite & selPcl;
  // Core status is read-only; the stack itself is never mapped
  wire [31:0] coreWord = (32'(acc_ff) << CORE_ACC_LSB)
    | (32'(flags_ff) << CORE_FLAG_LSB) | (32'(lvl_ff) << CORE_LVL_LSB)
    | (32'(intPend_ff) << CORE_PEND_BIT) | (32'(emi_ff) << CORE_EMI_BIT)
    | (32'(dummy_ff) << CORE_DUMMY_BIT);
  wire [31:0] rdWord = selPcl ? {24'h000000, progAddr_ff[7:0]}
    : (selCore ? coreWord : 32'h00000000);
  wire badAccess = ~selPcl & ~(selCore & ~pwrite);
  // A new write wins over the clear of the previous one
  wire nxt_pclReq = wrPcl | (pclReq_ff & ~(cycleEnd & applyPcl));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pclReq_ff <= 1'b0;
      pclData_ff <= 8'h00;
    end else begin
      pready_ff <= apbSetup;
      pslverr_ff <= apbSetup & badAccess;
      if (apbSetup) begin
        prdata_ff <= pwrite ? 32'h00000000 : rdWord;
      end
      pclReq_ff <= nxt_pclReq;
      if (wrPcl) begin
        pclData_ff <= pwdata[7:0];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign progAddr = progAddr_ff;
  assign intAck = intAck_ff;
  assign instrPhase = phase_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_PHASE_ORDER: assert property (
    phase_ff == PH_T1 |=> phase_ff == PH_T2 ##1 phase_ff == PH_T3
      ##1 phase_ff == PH_T4 ##1 phase_ff == PH_T1)
    else $error("phase sequence broken");

  AST_PC_STEP: assert property (
    cycleEnd && !takeBranch |=> progAddr_ff == $past(progAddr_ff) + 10'h1)
    else $error("program counter did not step by one");

  AST_BRANCH_DUMMY: assert property (
    // A branch taken during the dummy cycle itself earns a further one
    cycleEnd && takeBranch |=> dummy_ff [*4]
      ##1 (!dummy_ff || $past(takeBranch)))
    else $error("branch did not insert exactly one dummy cycle");

  AST_PCL_PAGE: assert property (
    cycleEnd && applyPcl |=> progAddr_ff[9:8] == $past(curPage)
      && progAddr_ff[7:0] == $past(pclData_ff) && dummy_ff)
    else $error("low byte write left the page or skipped the dummy");

  AST_SKIP: assert property (
    cycleEnd && skipTaken |=> progAddr_ff == $past(pc_ff) && dummy_ff)
    else $error("taken skip did not discard fetched instruction");

  AST_DUMMY_QUIET: assert property (
    cycleEnd && dummy_ff |=> $stable(acc_ff) && $stable(flags_ff))
    else $error("dummy cycle changed accumulator or flags");

  AST_FULL_INHIBIT: assert property (
    stackFull |-> !intAckNow)
    else $error("interrupt acknowledged with full stack");

  AST_CALL_OVERFLOW: assert property (
    cycleEnd && isCall && stackFull |=> lvl_ff == STACK_FULL_LVL
      && progAddr_ff == $past(jmpTarget))
    else $error("call on full stack misbehaved");

  AST_INT_VECTOR: assert property (
    cycleEnd && intAckNow |=> progAddr_ff == TIMEBASE_VECTOR
      && lvl_ff == $past(lvl_ff) + 2'h1 && intAck_ff)
    else $error("interrupt did not vector to fixed entry");

  AST_IMM_NIBBLE: assert property (
    cycleEnd && isOp && opRaw == OP_MOVI |=> acc_ff[7:4] == 4'h0)
    else $error("immediate load set high nibble");

  AST_APB_WAIT: assert property (
    apbSetup |=> pready_ff ##1 !pready_ff)
    else $error("APB answer timing wrong");

endmodule : psq_sequencer

/* File: hw/psq_stack_mem.sv */
// Return-address store with registered read data
`timescale 1ns/1ps
module psq_stack_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // Read port
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData_ff
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= mem[rdAddr];
    end
  end

endmodule : psq_stack_mem

/* File: test/tb_psq_sequencer.sv */
// Self-checking bench for the program sequencer core
`timescale 1ns/1ps
module tb_psq_sequencer
  import psq_pkg::*;
  ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PC_W-1:0] progAddr;
  logic [INSTR_W-1:0] progData = INSTR_NOP;
  logic intReq = 1'b0;
  logic intAck;
  logic [3:0] instrPhase;
  logic [12:0] rom [0:1023];
  logic [64:0] bq [$];
  logic [64:0] bnote;
  logic [9:0] fq [$];
  logic [9:0] aq [$];
  logic [1:0] ph = 2'h0;
  int miscompares = 0;
  int checked = 0;
  int seed = 31;

  initial begin
    forever #10 clk = ~clk;
  end

  psq_sequencer i_dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .progAddr(progAddr),
    .progData(progData), .intReq(intReq), .intAck(intAck),
    .instrPhase(instrPhase)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [12:0] ins(input psq_op_t o, input logic [3:0] i);
    return {1'b0, o, 3'b000, i};
  endfunction : ins

  function automatic logic [12:0] br(input logic c, input logic [9:0] t);
    return {1'b1, 1'b0, c, t};
  endfunction : br

  // Note holds {slverr, read mask, expected read data}
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [64:0] note);
    int n;
    bq.push_back(note);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle: the next call never re-drives psel in this time step
    @(posedge clk);
  endtask : apb

  task automatic wait_t1(input logic [9:0] a);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(instrPhase === PH_T1 && progAddr === a) && n < 400);
    if (n >= 400) miscompares++;
    @(posedge clk);
  endtask : wait_t1

  task automatic drain();
    int n;
    n = 0;
    while (fq.size() > 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) miscompares++;
  endtask : drain

  // ------------------------------------------------------------
  // Program memory and result watchers
  // ------------------------------------------------------------
  // Registered read is fine: data is only needed by the end of T4
  always @(posedge clk) begin
    progData <= rom[progAddr];
  end

  always @(posedge clk) begin
    if (!resetn) begin
      ph <= 2'h0;
    end else begin
      chk(instrPhase, 4'h1 << ph);
      ph <= ph + 2'h1;
    end
  end

  always @(posedge clk) begin
    if (resetn && psel && penable && pready === 1'b1) begin
      if (bq.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        bnote = bq.pop_front();
        chk({pslverr, prdata & bnote[63:32]}, {bnote[64], bnote[31:0]});
      end
    end
  end

  always @(negedge clk) begin
    if (resetn && instrPhase === PH_T1 && fq.size() > 0) begin
      chk(progAddr, fq.pop_front());
    end
  end

  // An acknowledge nobody expected means a full stack let it through
  always @(negedge clk) begin
    if (resetn && intAck === 1'b1) begin
      if (aq.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        chk({instrPhase, progAddr}, {4'h1, aq.pop_front()});
      end
    end
  end

  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [9:0] tr [11];
    int r;
    int n;
    logic saw;
    logic bad;
    tr = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h020,
      10'h021, 10'h004, 10'h005, 10'h006, 10'h007};
    for (int k = 0; k < 1024; k++) rom[k] = INSTR_NOP;
    rom[0] = ins(OP_MOVI, 4'hc) | 13'h0070;
    rom[1] = ins(OP_SWAPA, 4'h0);
    rom[2] = ins(OP_RLCA, 4'h0);
    rom[3] = br(1'b1, 10'h020);
    rom[4] = ins(OP_SZA, 4'h0);
    rom[5] = br(1'b0, 10'h0f0);
    rom[6] = br(1'b0, 10'h140);
    rom[10'h008] = ins(OP_INTERRUPT_RETURN_OP, 4'h0);
    rom[10'h020] = ins(OP_RETA, 4'h0);
    rom[10'h140] = ins(OP_MOVI, 4'h9);
    rom[10'h141] = ins(OP_ADDI, 4'h7);
    rom[10'h142] = ins(OP_XORI, 4'h3);
    rom[10'h143] = ins(OP_ANDI, 4'he);
    rom[10'h144] = ins(OP_INCA, 4'h0);
    rom[10'h145] = ins(OP_RLA, 4'h0);
    rom[10'h146] = ins(OP_SWAPA, 4'h0);
    rom[10'h147] = ins(OP_CPLA, 4'h0);
    rom[10'h148] = ins(OP_DECA, 4'h0);
    rom[10'h149] = ins(OP_SUBI, 4'he);
    rom[10'h14a] = ins(OP_ORI, 4'h5);
    rom[10'h14b] = ins(OP_ADCI, 4'h3);
    rom[10'h14c] = ins(OP_SBCI, 4'h4);
    rom[10'h14d] = ins(OP_RRCA, 4'h0);
    rom[10'h14e] = ins(OP_DAA, 4'h0);
    rom[10'h14f] = ins(OP_SNZA, 4'h0);
    // Runs only if the taken skip fails to discard it
    rom[10'h150] = ins(OP_MOVI, 4'h0);
    rom[10'h151] = ins(OP_MOVPCL, 4'h0);
    // Both loop words jump, so a missing dummy cycle shows in the trace
    rom[10'h130] = br(1'b0, 10'h130);
    rom[10'h131] = br(1'b0, 10'h130);
    rom[10'h160] = br(1'b0, 10'h160);
    rom[10'h161] = br(1'b0, 10'h160);
    rom[10'h180] = ins(OP_EI, 4'h0);
    rom[10'h181] = br(1'b1, 10'h190);
    rom[10'h190] = br(1'b1, 10'h1a0);
    rom[10'h191] = ins(OP_RET, 4'h0);
    rom[10'h1a0] = br(1'b1, 10'h1b0);
    rom[10'h1a1] = ins(OP_RET, 4'h0);
    rom[10'h1b0] = br(1'b0, 10'h1b0);
    rom[10'h1b1] = br(1'b0, 10'h1b0);
    rom[10'h1c0] = ins(OP_RET, 4'h0);
    foreach (tr[k]) fq.push_back(tr[k]);
    for (int k = 10'h140; k <= 10'h152; k++) fq.push_back(k[9:0]);
    repeat (2) begin
      fq.push_back(10'h130);
      fq.push_back(10'h131);
    end
    repeat (3) @(posedge clk);
    chk({instrPhase, progAddr}, {4'h1, 10'h000});
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    drain();
    apb(1'b0, OFF_CORE_STATUS, 32'h0, {1'b0, 32'h0000b1ff, 32'h00000130});
    r = $random(seed);
    apb(1'b0, 12'h008 | (r[11:0] & 12'hff8), r, {1'b1, 32'hffffffff, 32'h0});
    apb(1'b1, OFF_CORE_STATUS, r, {1'b1, 32'h0, 32'h0});
    apb(1'b0, OFF_CORE_STATUS, 32'h0, {1'b0, 32'h0000b1ff, 32'h00000130});
    apb(1'b1, OFF_PC_LOW_BYTE, {r[31:8], 8'h60}, {1'b0, 32'h0, 32'h0});
    wait_t1(10'h160);
    fq.push_back(10'h161);
    fq.push_back(10'h160);
    drain();
    apb(1'b0, OFF_PC_LOW_BYTE, 32'h0, {1'b0, 32'hfffffffe, 32'h00000060});
    apb(1'b1, OFF_PC_LOW_BYTE, 32'h00000080, {1'b0, 32'h0, 32'h0});
    wait_t1(10'h1b0);
    apb(1'b0, OFF_CORE_STATUS, 32'h0, {1'b0, 32'h0000f1ff, 32'h0000a130});
    intReq <= 1'b1;
    @(posedge clk);
    intReq <= 1'b0;
    repeat (24) @(posedge clk);
    apb(1'b0, OFF_CORE_STATUS, 32'h0, {1'b0, 32'h0000f1ff, 32'h0000e130});
    aq.push_back(TIMEBASE_VECTOR);
    apb(1'b1, OFF_PC_LOW_BYTE, 32'h000000c0, {1'b0, 32'h0, 32'h0});
    n = 0;
    while (intAck !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(aq.size(), 0);
    saw = 1'b0;
    bad = 1'b0;
    repeat (80) begin
      @(negedge clk);
      if (instrPhase === PH_T1 && progAddr === 10'h191) saw = 1'b1;
      if (instrPhase === PH_T1 && progAddr === 10'h182) bad = 1'b1;
    end
    chk({saw, bad}, 2'b10);
    give_verdict();
  end
endmodule : tb_psq_sequencer
